// *** rbm_pkg.sv ***
// constants and types for the receive buffer manager
package rbm_pkg;

  localparam logic [7:0]  REG_CMD    = 8'h00;
  localparam logic [7:0]  REG_CFG    = 8'h04;
  localparam logic [7:0]  REG_RSTART = 8'h08;
  localparam logic [7:0]  REG_REND   = 8'h0c;
  localparam logic [7:0]  REG_RRP    = 8'h10;
  localparam logic [7:0]  REG_RWP    = 8'h14;
  localparam logic [7:0]  REG_RUPPER = 8'h18;
  localparam logic [7:0]  REG_CURRENT_DESCRIPTOR_ADDRESS   = 8'h1c;
  localparam logic [7:0]  REG_DUPPER = 8'h20;
  localparam logic [7:0]  REG_END_OF_BUFFER_BOUNDARY   = 8'h24;
  localparam logic [7:0]  REG_BUF    = 8'h28;
  localparam logic [7:0]  REG_WORDS  = 8'h2c;
  localparam logic [7:0]  REG_STAT   = 8'h30;
  localparam logic [7:0]  REG_SEQ    = 8'h34;

  localparam int          BIT_CMD_RD  = 0;
  localparam int          BIT_MODE32  = 0;
  localparam int          BIT_DEXH    = 0;
  localparam int          BIT_BEXH    = 1;
  localparam int          BIT_HALT    = 2;

  localparam logic [15:0] END_OF_BUFFER_BOUNDARY_RESET  = 16'h02f8;
  localparam logic [2:0]  RES_LAST    = 3'h3;
  localparam logic [2:0]  DSC_LAST_WR = 3'h4;
  localparam logic [2:0]  DSC_LINK    = 3'h5;
  localparam logic [2:0]  DSC_OWN     = 3'h6;

  typedef enum logic [6:0] {
    S_IDLE   = 7'b0000001,
    S_FETCH  = 7'b0000010,
    S_EOLCHK = 7'b0000100,
    S_RECV   = 7'b0001000,
    S_DWRITE = 7'b0010000,
    S_LINK   = 7'b0100000,
    S_OWN    = 7'b1000000
  } rbm_state_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        burst;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rbm_mem_s;

  typedef struct packed {
    rbm_state_e  st;
    logic [2:0]  idx;
    logic        cmd_rd;
    logic        mode32;
    logic [15:0] rstart;
    logic [15:0] rend;
    logic [15:0] resource_read_pointer;
    logic [15:0] resource_write_pointer;
    logic [15:0] rupper;
    logic [15:0] current_descriptor_address;
    logic [15:0] ocrda;
    logic [15:0] dupper;
    logic [15:0] end_of_buffer_boundary;
    logic [31:0] buf_addr;
    logic [31:0] words;
    logic [31:0] sbuf;
    logic [31:0] swords;
    logic        end_of_list_flag;
    logic        from_eol;
    logic        fetch_pend;
    logic        fetch_cmd;
    logic        dexh;
    logic        bexh;
    logic        halt;
    logic [7:0]  rba_seq;
    logic [7:0]  pkt_seq;
    logic [15:0] bcnt;
    logic [15:0] rstat;
    logic [31:0] hrdata;
    logic        wr_pend;
    logic [7:0]  wr_addr;
  } rbm_regs_s;

endpackage : rbm_pkg

// *** rbm_core.sv ***
// receive buffer and descriptor manager with ahb-lite registers and dma master port
`timescale 1ns/1ps
`default_nettype none
module rbm_core
  import rbm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output rbm_mem_s         mem_o,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        rx_start,
  output logic             rx_ack,
  input  wire logic        rx_valid,
  input  wire logic [31:0] rx_data,
  output logic             rx_ready,
  input  wire logic        rx_end,
  input  wire logic        rx_good,
  input  wire logic [15:0] rx_status,
  input  wire logic [15:0] rx_bytes,
  output logic             rx_halted
);

  rbm_regs_s s;
  rbm_regs_s next_s;

  // ------------------------------------------------------------
  // address helpers and register read mux
  // ------------------------------------------------------------
  function automatic logic [15:0] fld(input logic [15:0] base, input logic [2:0] i, input logic m32);
    fld = base + (m32 ? {11'h0, i, 2'b00} : {12'h0, i, 1'b0});
  endfunction : fld

  function automatic logic [31:0] rd_mux(input rbm_regs_s r, input logic [7:0] a);
    case (a)
      REG_CMD:    rd_mux = {31'h0, r.cmd_rd};
      REG_CFG:    rd_mux = {31'h0, r.mode32};
      REG_RSTART: rd_mux = {16'h0, r.rstart};
      REG_REND:   rd_mux = {16'h0, r.rend};
      REG_RRP:    rd_mux = {16'h0, r.resource_read_pointer};
      REG_RWP:    rd_mux = {16'h0, r.resource_write_pointer};
      REG_RUPPER: rd_mux = {16'h0, r.rupper};
      REG_CURRENT_DESCRIPTOR_ADDRESS:   rd_mux = {16'h0, r.current_descriptor_address};
      REG_DUPPER: rd_mux = {16'h0, r.dupper};
      REG_END_OF_BUFFER_BOUNDARY:   rd_mux = {16'h0, r.end_of_buffer_boundary};
      REG_BUF:    rd_mux = r.buf_addr;
      REG_WORDS:  rd_mux = r.words;
      REG_STAT:   rd_mux = {29'h0, r.halt, r.bexh, r.dexh};
      REG_SEQ:    rd_mux = {16'h0, r.rba_seq, r.pkt_seq};
      default:    rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  logic [15:0] end_of_buffer_boundary_eff;
  logic [31:0] step_b;
  logic [31:0] step_w;
  logic [15:0] step_r;
  logic [15:0] rrp_adv;
  logic        low_room;
  logic        take;

  always_comb begin
    end_of_buffer_boundary_eff = s.mode32 ? {s.end_of_buffer_boundary[15:1], 1'b0} : s.end_of_buffer_boundary;
    step_b   = s.mode32 ? 32'h4 : 32'h2;
    step_w   = s.mode32 ? 32'h2 : 32'h1;
    step_r   = s.mode32 ? 16'h10 : 16'h8;
    rrp_adv  = s.resource_read_pointer + step_r;
    low_room = s.words < {16'h0, end_of_buffer_boundary_eff};
    take     = ce & mem_ack;
  end

  // ------------------------------------------------------------
  // dma master port
  // ------------------------------------------------------------
  always_comb begin
    mem_o       = '0;
    mem_o.burst = s.st inside {S_FETCH, S_DWRITE, S_LINK};
    case (s.st)
      S_FETCH: begin
        mem_o.req  = 1'b1;
        mem_o.addr = {s.rupper, fld(s.resource_read_pointer, s.idx, s.mode32)};
      end
      S_EOLCHK, S_LINK: begin
        mem_o.req  = 1'b1;
        mem_o.addr = {s.dupper, fld(s.current_descriptor_address, DSC_LINK, s.mode32)};
      end
      S_RECV: begin
        mem_o.req   = rx_valid;
        mem_o.we    = 1'b1;
        mem_o.addr  = s.buf_addr;
        mem_o.wdata = rx_data;
      end
      S_DWRITE: begin
        mem_o.req  = 1'b1;
        mem_o.we   = 1'b1;
        mem_o.addr = {s.dupper, fld(s.current_descriptor_address, s.idx, s.mode32)};
        case (s.idx)
          3'h0:    mem_o.wdata = {16'h0, s.rstat};
          3'h1:    mem_o.wdata = {16'h0, s.bcnt};
          3'h2:    mem_o.wdata = {16'h0, s.sbuf[15:0]};
          3'h3:    mem_o.wdata = {16'h0, s.sbuf[31:16]};
          default: mem_o.wdata = {16'h0, s.rba_seq, s.pkt_seq};
        endcase
      end
      S_OWN: begin
        mem_o.req   = 1'b1;
        mem_o.we    = 1'b1;
        mem_o.addr  = {s.dupper, fld(s.ocrda, DSC_OWN, s.mode32)};
        mem_o.wdata = 32'h0;
      end
      default: mem_o = '0;
    endcase
  end

  assign rx_ready  = (s.st == S_RECV) & take;
  assign rx_halted = s.halt;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s.hrdata;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    rx_ack = 1'b0;
    // bus slave: address phase capture, data phase write
    next_s.wr_pend = hsel & hready & htrans[1] & hwrite;
    next_s.wr_addr = {haddr[7:2], 2'b00};
    if (hsel & hready & htrans[1] & ~hwrite) begin
      next_s.hrdata = rd_mux(s, {haddr[7:2], 2'b00});
    end
    if (s.wr_pend) begin
      case (s.wr_addr)
        REG_CMD:    next_s.cmd_rd = s.cmd_rd | hwdata[BIT_CMD_RD];
        REG_CFG:    next_s.mode32 = hwdata[BIT_MODE32];
        REG_RSTART: next_s.rstart = hwdata[15:0];
        REG_REND:   next_s.rend   = hwdata[15:0];
        REG_RRP:    next_s.resource_read_pointer    = hwdata[15:0];
        REG_RWP:    next_s.resource_write_pointer    = hwdata[15:0];
        REG_RUPPER: next_s.rupper = hwdata[15:0];
        REG_CURRENT_DESCRIPTOR_ADDRESS:   next_s.current_descriptor_address   = hwdata[15:0];
        REG_DUPPER: next_s.dupper = hwdata[15:0];
        REG_END_OF_BUFFER_BOUNDARY:   next_s.end_of_buffer_boundary   = hwdata[15:0];
        REG_STAT: begin
          next_s.dexh = s.dexh & ~hwdata[BIT_DEXH];
          next_s.bexh = s.bexh & ~hwdata[BIT_BEXH];
          next_s.halt = s.halt & ~hwdata[BIT_HALT];
        end
        REG_SEQ: begin
          next_s.rba_seq = hwdata[15:8];
          next_s.pkt_seq = hwdata[7:0];
        end
        default: next_s.end_of_list_flag = s.end_of_list_flag;
      endcase
    end
    // engine; hardware sets come after software clears so they win
    case (s.st)
      S_IDLE: begin
        if ((s.fetch_pend & ~s.bexh) | s.cmd_rd) begin
          next_s.fetch_cmd = ~(s.fetch_pend & ~s.bexh);
          next_s.st        = S_FETCH;
          next_s.idx       = 3'h0;
        end else if (rx_start & ~s.halt) begin
          if (s.end_of_list_flag) begin
            next_s.st = S_EOLCHK;
          end else begin
            rx_ack        = ce;
            next_s.sbuf   = s.buf_addr;
            next_s.swords = s.words;
            next_s.st     = S_RECV;
          end
        end
      end
      S_FETCH: begin
        if (take) begin
          next_s.idx = s.idx + 3'h1;
          case (s.idx)
            3'h0:    next_s.buf_addr[15:0]  = mem_rdata[15:0];
            3'h1:    next_s.buf_addr[31:16] = mem_rdata[15:0];
            3'h2:    next_s.words[15:0]     = mem_rdata[15:0];
            default: next_s.words[31:16]    = mem_rdata[15:0];
          endcase
          if (s.idx == RES_LAST) begin
            next_s.resource_read_pointer = (rrp_adv == s.rend) ? s.rstart : rrp_adv;
            if (((rrp_adv == s.rend) ? s.rstart : rrp_adv) == s.resource_write_pointer) begin
              next_s.bexh = 1'b1;
            end
            if (s.fetch_cmd) begin
              next_s.cmd_rd = 1'b0;
            end else begin
              next_s.rba_seq = s.rba_seq + 8'h1;
              next_s.pkt_seq = 8'h0;
            end
            next_s.fetch_pend = 1'b0;
            next_s.st         = S_IDLE;
          end
        end
      end
      S_EOLCHK: begin
        if (take) begin
          if (mem_rdata[0]) begin
            next_s.halt = 1'b1;
            next_s.st   = S_IDLE;
          end else begin
            next_s.ocrda    = s.current_descriptor_address;
            next_s.current_descriptor_address     = {mem_rdata[15:1], 1'b0};
            next_s.end_of_list_flag      = 1'b0;
            next_s.from_eol = 1'b1;
            next_s.st       = S_OWN;
          end
        end
      end
      S_RECV: begin
        if (rx_valid & take) begin
          next_s.buf_addr = s.buf_addr + step_b;
          next_s.words    = s.words - step_w;
        end else if (ce & rx_end) begin
          if (rx_good) begin
            next_s.rstat = rx_status;
            next_s.bcnt  = rx_bytes;
            next_s.idx   = 3'h0;
            next_s.st    = S_DWRITE;
          end else begin
            next_s.buf_addr = s.sbuf;
            next_s.words    = s.swords;
            next_s.st       = S_IDLE;
          end
        end
      end
      S_DWRITE: begin
        if (take) begin
          next_s.idx = s.idx + 3'h1;
          if (s.idx == DSC_LAST_WR) begin
            next_s.st = S_LINK;
          end
        end
      end
      S_LINK: begin
        if (take) begin
          next_s.pkt_seq = s.pkt_seq + 8'h1;
          next_s.st      = S_IDLE;
          if (low_room) begin
            next_s.fetch_pend = 1'b1;
          end
          if (mem_rdata[0]) begin
            next_s.end_of_list_flag  = 1'b1;
            next_s.dexh = 1'b1;
          end else begin
            next_s.ocrda    = s.current_descriptor_address;
            next_s.current_descriptor_address     = {mem_rdata[15:1], 1'b0};
            next_s.from_eol = 1'b0;
            next_s.st       = S_OWN;
          end
        end
      end
      S_OWN: begin
        if (take) begin
          if (s.from_eol) begin
            rx_ack        = ce;
            next_s.sbuf   = s.buf_addr;
            next_s.swords = s.words;
            next_s.st     = S_RECV;
          end else begin
            next_s.st = S_IDLE;
          end
        end
      end
      default: next_s.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s      <= '0;
      s.st   <= S_IDLE;
      s.end_of_buffer_boundary <= END_OF_BUFFER_BOUNDARY_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_cmd_clear;
    (s.st == S_FETCH) && (s.idx == RES_LAST) && take && s.fetch_cmd |=> !s.cmd_rd;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("read command not cleared");

  property p_wrap;
    (s.st == S_FETCH) && (s.idx == RES_LAST) && take && (rrp_adv == s.rend) |=> s.resource_read_pointer == $past(s.rstart);
  endproperty
  a_wrap: assert property (p_wrap) else $error("read pointer did not wrap");

  property p_dec;
    (s.st == S_RECV) && rx_valid && take |=> s.words == $past(s.words) - $past(step_w);
  endproperty
  a_dec: assert property (p_dec) else $error("word count step wrong");

  property p_restore;
    (s.st == S_RECV) && ce && rx_end && !rx_valid && !rx_good |=> s.buf_addr == $past(s.sbuf)
      && s.words == $past(s.swords);
  endproperty
  a_restore: assert property (p_restore) else $error("rejected packet not restored");

  property p_own;
    s.st == S_OWN |-> mem_o.req && mem_o.we && mem_o.wdata == 32'h0
      && mem_o.addr == {s.dupper, s.ocrda + (s.mode32 ? 16'h0018 : 16'h000c)};
  endproperty
  a_own: assert property (p_own) else $error("ownership release not zero");

  property p_upper;
    s.st == S_FETCH |-> mem_o.addr[31:16] == s.rupper;
  endproperty
  a_upper: assert property (p_upper) else $error("ring address upper half wrong");

  property p_eol;
    (s.st == S_LINK) && take && mem_rdata[0] |=> s.dexh && s.end_of_list_flag && s.current_descriptor_address == $past(s.current_descriptor_address) && s.st == S_IDLE;
  endproperty
  a_eol: assert property (p_eol) else $error("end of list not kept");

  property p_bexh;
    $rose(s.bexh) |-> $past(s.st == S_FETCH && s.idx == RES_LAST);
  endproperty
  a_bexh: assert property (p_bexh) else $error("exhausted flag set mid fetch");

  property p_burst;
    (s.st == S_DWRITE) && (s.idx == DSC_LAST_WR) && take |=> s.st == S_LINK ##0 mem_o.burst;
  endproperty
  a_burst: assert property (p_burst) else $error("descriptor burst broken");

endmodule : rbm_core
`default_nettype wire

// *** rbm_mem_model.sv ***
// system memory model answering the dma port with random latency
`timescale 1ns/1ps
`default_nettype none
module rbm_mem_model
  import rbm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire rbm_mem_s    mem_i,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  // ----------------------------------------
  // word store keyed by byte address
  // ----------------------------------------
  logic [31:0] mem [logic [31:0]];
  integer      seed = 32'h51;
  integer      wait_c;

  // ack is a one-cycle pulse; idle data is the inverse of the last value
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_c = 0;
    end else if (mem_ack) begin
      if (mem_i.we)
        mem[mem_i.addr] = mem_i.wdata;
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_c = {$random(seed)} % 3;
    end else if (mem_i.req) begin
      if (wait_c == 0) begin
        mem_ack   <= 1'b1;
        mem_rdata <= mem.exists(mem_i.addr) ? mem[mem_i.addr] : ~mem_rdata;
      end else
        wait_c = wait_c - 1;
    end
  end
endmodule : rbm_mem_model
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the receive buffer manager
`timescale 1ns/1ps
`default_nettype none
module tb
  import rbm_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rx_data = 32'h0;
  logic        rx_start = 1'b0;
  logic        rx_valid = 1'b0;
  logic        rx_end = 1'b0;
  logic        rx_good = 1'b0;
  logic [15:0] rx_status = 16'h0;
  logic [15:0] rx_bytes = 16'h0;
  logic [15:0] st;
  logic [31:0] hrdata, mem_rdata, q;
  logic        hreadyout, hresp, mem_ack, rx_ack, rx_ready, rx_halted;
  rbm_mem_s    mem_o;
  wire         hready = hreadyout;
  integer      seed = 32'hae8e;
  integer      failures = 0;
  integer      samples_checked = 0;
  integer      cyc = 0;
  logic [31:0] pd [8];
  logic [31:0] mi [14] = '{32'h00010100, 32'h00010102, 32'h00010104, 32'h00010106, 32'h00010108,
    32'h0001010a, 32'h0001010c, 32'h0001010e, 32'h0002020a, 32'h0002020c, 32'h0002021a, 32'h0002021c,
    32'h0002022a, 32'h0002022c};
  logic [15:0] mv [14] = '{16'h1000, 16'h0003, 16'h0010, 16'h0000, 16'h2000, 16'h0004, 16'h0040,
    16'h0000, 16'h0210, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
  logic [7:0]  ra [8] = '{REG_RSTART, REG_REND, REG_RRP, REG_RWP, REG_RUPPER, REG_CURRENT_DESCRIPTOR_ADDRESS, REG_DUPPER, REG_END_OF_BUFFER_BOUNDARY};
  logic [15:0] rv [8] = '{16'h0100, 16'h0110, 16'h0100, 16'h0100, 16'h0001, 16'h0200, 16'h0002, 16'h000c};

  rbm_core u_rbm_core (.clk, .arst_n, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .mem_o, .mem_ack, .mem_rdata, .rx_start, .rx_ack, .rx_valid,
    .rx_data, .rx_ready, .rx_end, .rx_good, .rx_status, .rx_bytes, .rx_halted);
  rbm_mem_model u_rbm_mem_model (.clk, .arst_n, .mem_i(mem_o), .mem_ack, .mem_rdata);

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      print_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task print_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus

  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rd

  task mm(input logic [31:0] a, input logic [15:0] e, input string n);
    chk(n, {16'h0, e}, {16'h0, u_rbm_mem_model.mem[a][15:0]});
  endtask : mm

  // packet words with random data; returns early when reception ceases
  task pkt(input int n, input logic g);
    int k;
    rx_start <= 1'b1;
    do @(posedge clk); while (rx_ack !== 1'b1 && rx_halted !== 1'b1);
    rx_start <= 1'b0;
    if (rx_halted === 1'b1)
      return;
    for (k = 0; k < n; k++) begin
      pd[k] = $random(seed);
      rx_valid <= 1'b1;
      rx_data  <= pd[k];
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    st = $random(seed);
    rx_valid  <= 1'b0;
    rx_end    <= 1'b1;
    rx_good   <= g;
    rx_status <= st;
    rx_bytes  <= 16'(n * 4);
    @(posedge clk);
    rx_end <= 1'b0;
    k = 0;
    while (k < 4) begin
      @(posedge clk);
      k = mem_o.req ? 0 : k + 1;
    end
  endtask : pkt

  task dsc(input logic [15:0] b, input logic [15:0] n, input logic [31:0] p);
    mm({16'h0002, b}, st, "status field");
    mm({16'h0002, b + 16'h2}, n * 4, "byte count");
    mm({16'h0002, b + 16'h4}, p[15:0], "pointer low");
    mm({16'h0002, b + 16'h6}, p[31:16], "pointer high");
  endtask : dsc

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int k = 0; k < 14; k++)
      u_rbm_mem_model.mem[mi[k]] = {16'h0, mv[k]};
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(REG_END_OF_BUFFER_BOUNDARY, 32'h2f8, "boundary reset");
    for (int k = 0; k < 8; k++)
      bus(1'b1, ra[k], {16'h0, rv[k]});
    bus(1'b1, REG_CMD, 32'h1);
    do bus(1'b0, REG_CMD, 32'h0); while (q[BIT_CMD_RD] !== 1'b0);
    chk("command bit", 32'h0, q);
    rd(REG_BUF, 32'h00031000, "buffer address");
    rd(REG_WORDS, 32'h10, "word count");
    rd(REG_RRP, 32'h108, "read pointer");
    rd(REG_STAT, 32'h0, "status");
    pkt(3, 1'b0);
    rd(REG_BUF, 32'h00031000, "buffer after reject");
    rd(REG_WORDS, 32'h10, "count after reject");
    pkt(5, 1'b1);
    for (int k = 0; k < 5; k++)
      chk("packet word", pd[k], u_rbm_mem_model.mem[32'h00031000 + 2 * k]);
    dsc(16'h0200, 16'd5, 32'h00031000);
    mm(32'h0002020c, 16'h0, "ownership returned");
    rd(REG_CURRENT_DESCRIPTOR_ADDRESS, 32'h210, "descriptor address");
    rd(REG_BUF, 32'h00042000, "next buffer");
    rd(REG_WORDS, 32'h40, "next count");
    rd(REG_RRP, 32'h100, "pointer wrap");
    rd(REG_STAT, 32'h2, "buffers exhausted");
    pkt(2, 1'b1);
    dsc(16'h0210, 16'd2, 32'h00042000);
    mm(32'h0002021c, 16'h1, "ownership kept");
    rd(REG_STAT, 32'h3, "descriptors exhausted");
    rd(REG_BUF, 32'h00042004, "same buffer");
    rd(REG_WORDS, 32'h3e, "count stepped");
    pkt(1, 1'b1);
    chk("halted", 32'h1, {31'h0, rx_halted});
    rd(REG_STAT, 32'h7, "halt status");
    u_rbm_mem_model.mem[32'h0002021a] = 32'h0220;
    bus(1'b1, REG_STAT, 32'h5);
    pkt(1, 1'b1);
    mm(32'h0002021c, 16'h0, "ownership released");
    dsc(16'h0220, 16'd1, 32'h00042004);
    chk("resumed", 32'h0, {31'h0, rx_halted});
    u_rbm_mem_model.mem[32'h0002022a] = 32'h0230;
    u_rbm_mem_model.mem[32'h0002023a] = 32'h0001;
    bus(1'b1, REG_END_OF_BUFFER_BOUNDARY, 32'h40);
    pkt(1, 1'b1);
    mm(32'h0002022c, 16'h0, "ownership after append");
    dsc(16'h0230, 16'd1, 32'h00042006);
    rd(REG_BUF, 32'h00042008, "fetch held while exhausted");
    bus(1'b1, REG_STAT, 32'h2);
    repeat (30) @(posedge clk);
    rd(REG_BUF, 32'h00031000, "fetch after clear");
    rd(REG_WORDS, 32'h10, "count after clear");
    rd(REG_STAT, 32'h1, "status after clear");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
